// file: design/rfcs_pkg.sv
// Constants and carriers for the receive frame check and filter block.
// Assumes one clock domain (hclk); the line clock is sampled as data.
package rfcs_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, low 8 address bits)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_UNI_LO = 8'h04;
    localparam logic [7:0]  OFS_UNI_HI = 8'h08;
    localparam logic [7:0]  OFS_PS_LO  = 8'h0c;
    localparam logic [7:0]  OFS_PS_HI  = 8'h10;
    localparam logic [7:0]  OFS_STATS  = 8'h14;
    localparam logic [7:0]  OFS_NFRM   = 8'h18;
    localparam logic [7:0]  OFS_TBL    = 8'h40;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
    localparam int          TBL_EN_B   = 48;

    // Control bit positions
    localparam int CB_LENCHK = 0;
    localparam int CB_FCSP   = 1;
    localparam int CB_PROM   = 2;
    localparam int CB_VLAN   = 3;
    localparam int CB_JUMBO  = 4;
    localparam int CB_FC     = 5;

    // Statistics vector bit positions
    localparam int ST_GOOD   = 0;
    localparam int ST_BAD    = 1;
    localparam int ST_FCS    = 2;
    localparam int ST_BCAST  = 3;
    localparam int ST_MCAST  = 4;
    localparam int ST_LEN_LO = 5;
    localparam int ST_LEN_HI = 18;
    localparam int ST_CTRL   = 19;
    localparam int ST_OOB    = 20;
    localparam int ST_VLAN   = 21;
    localparam int ST_BV     = 22;
    localparam int ST_FCFRM  = 23;
    localparam int ST_BADOP  = 24;
    localparam int ST_LENERR = 25;
    localparam int ST_RSVD   = 26;
    localparam int ST_MATCH  = 27;

    // ------------------------------------------------------------
    // Frame constants
    // ------------------------------------------------------------
    localparam logic [7:0]  SFD         = 8'hd5;
    localparam logic [15:0] LEN_MIN     = 16'h002e;
    localparam logic [15:0] LT_TYPE_MIN = 16'h0600;
    localparam logic [15:0] MIN_FRM     = 16'h0040;
    localparam logic [15:0] MAX_FRM     = 16'h05ee;
    localparam logic [15:0] MAX_VLAN    = 16'h05f2;
    localparam logic [15:0] HDR_LEN     = 16'h000e;
    localparam logic [15:0] OVH_LEN     = 16'h0012;
    localparam logic [15:0] LEN_SAT     = 16'h3fff;
    localparam logic [15:0] TYPE_CTRL   = 16'h8808;
    localparam logic [15:0] TYPE_VLAN   = 16'h8100;
    localparam logic [15:0] OPC_PAUSE   = 16'h0001;
    localparam logic [47:0] DA_BCAST    = 48'hffff_ffff_ffff;
    localparam logic [47:0] DA_PAUSE    = 48'h0180_c200_0001;
    localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY    = 32'hedb8_8320;
    localparam logic [31:0] CRC_RESID   = 32'hdebb_20e3;
    localparam int          PIPE_D      = 6;
    localparam logic [2:0]  FLUSH_N     = 3'h5;

    // GMII receive pins
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [7:0] d;
    } rfcs_gmii_t;

    // Client receive outputs
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       good;
        logic       bad;
    } rfcs_client_t;

endpackage

// file: design/rfcs_rx_filter.sv
// Receive frame qualification: length checks, pad removal, address filter,
// statistics vector, AHB-Lite config. Line clock is sampled by hclk.
`timescale 1ns/1ps

module rfcs_rx_filter #(
    parameter bit FILT_EN = 1'b1,
    parameter bit MGMT_EN = 1'b1,
    parameter int TBL_N   = 4
)(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  gmii_rx_clk,
    input  wire rfcs_pkg::rfcs_gmii_t  gmii_rx,
    input  wire logic [47:0]           uni_addr_in,
    output rfcs_pkg::rfcs_client_t     rx_client,
    output logic [27:0]                rx_stats_vec,
    output logic                       rx_stats_valid
);
    import rfcs_pkg::*;

    localparam int TW = (TBL_N > 0) ? TBL_N : 1;
    localparam bit TBL_ON = MGMT_EN && (TBL_N > 0);

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_FRAME = 2'b01,
        S_FLUSH = 2'b10
    } rfcs_fsm_t;

    typedef struct packed {
        logic [2:0]             lclk;
        rfcs_gmii_t             g1;
        rfcs_gmii_t             g2;
        rfcs_fsm_t              st;
        logic [15:0]            cnt;
        logic [31:0]            crc;
        logic                   er;
        logic [47:0]            da;
        logic [15:0]            lt;
        logic [15:0]            op;
        logic                   rej;
        logic [2:0]             fl;
        logic [PIPE_D-1:0][8:0] pipe;
        logic [31:0]            ctrl;
        logic [31:0]            uni_lo;
        logic [31:0]            uni_hi;
        logic [31:0]            ps_lo;
        logic [31:0]            ps_hi;
        logic [31:0]            nfrm;
        logic [TW-1:0][48:0]    tbl;
        logic [7:0]             adr;
        logic                   wr;
        logic                   rd;
        logic [31:0]            hrdata;
        logic                   hrdy;
        rfcs_client_t           cl;
        logic [27:0]            sv;
        logic                   svld;
    } rfcs_state_t;

    rfcs_state_t r_r;
    rfcs_state_t r_nxt;

    // ------------------------------------------------------------
    // Derived terms
    // ------------------------------------------------------------
    logic          lenchk;
    logic          fcs_pass;
    logic          promisc;
    logic          vlan_en;
    logic          jumbo_en;
    logic          fc_en;
    logic [47:0]   uni;
    logic [47:0]   psrc;
    logic [TW-1:0] tbl_hit;
    logic          acc;
    logic          slot;
    logic          rej_now;
    logic          pad_cut;
    logic [15:0]   dlen;
    logic          len_err;
    logic          is_ctl;
    logic          is_vlan;
    logic          oob;
    logic          fcs_err;
    logic          err0;
    logic          fc_frm;
    logic          bad;

    // Control bits
    assign lenchk   = r_r.ctrl[CB_LENCHK];
    assign fcs_pass = r_r.ctrl[CB_FCSP];
    assign promisc  = r_r.ctrl[CB_PROM];
    assign vlan_en  = r_r.ctrl[CB_VLAN];
    assign jumbo_en = r_r.ctrl[CB_JUMBO];
    assign fc_en    = r_r.ctrl[CB_FC];
    // Station address source
    assign uni  = MGMT_EN ? {r_r.uni_hi[15:0], r_r.uni_lo} : uni_addr_in;
    assign psrc = {r_r.ps_hi[15:0], r_r.ps_lo};
    // Table compare per entry
    genvar gi;
    generate
        for (gi = 0; gi < TW; gi++)
        begin : g_tbl
            assign tbl_hit[gi] = TBL_ON && r_r.tbl[gi][TBL_EN_B]
                                 && (r_r.tbl[gi][47:0] == r_r.da);
        end
    endgenerate

    // Destination acceptance
    assign acc = promisc || !FILT_EN || (r_r.da == DA_BCAST) || (r_r.da == DA_PAUSE)
                 || (r_r.da == psrc) || (r_r.da == uni) || (|tbl_hit);
    // Falling line-clock edge: data stable mid-bit
    assign slot    = r_r.lclk[2] && !r_r.lclk[1];
    assign rej_now = (r_r.st == S_FRAME && r_r.cnt == 16'h0006) ? !acc : r_r.rej;
    // Pad bytes past the length value
    assign pad_cut = lenchk && !fcs_pass && (r_r.lt < LEN_MIN) && (r_r.cnt >= HDR_LEN)
                     && ((r_r.cnt - HDR_LEN) >= r_r.lt);
    // End-of-frame checks
    assign dlen    = r_r.cnt - OVH_LEN;
    assign len_err = (lenchk && (r_r.lt >= LEN_MIN) && (r_r.lt < LT_TYPE_MIN)
                      && (dlen != r_r.lt))
                     || ((r_r.lt < LEN_MIN) && (r_r.cnt != MIN_FRM));
    assign is_ctl  = (r_r.lt == TYPE_CTRL);
    assign is_vlan = vlan_en && (r_r.lt == TYPE_VLAN);
    assign oob     = !jumbo_en && (r_r.cnt > (is_vlan ? MAX_VLAN : MAX_FRM));
    assign fcs_err = r_r.er || (r_r.crc != CRC_RESID);
    assign err0    = fcs_err || (r_r.cnt < MIN_FRM) || oob || len_err
                     || (is_ctl && r_r.cnt != MIN_FRM);
    assign fc_frm  = !err0 && fc_en && is_ctl && (r_r.op == OPC_PAUSE)
                     && ((r_r.da == DA_PAUSE) || (r_r.da == psrc));
    assign bad     = err0 || fc_frm;

    // One byte of reflected CRC-32
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c;
        for (int i = 0; i < 8; i++)
        begin
            x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        r_nxt = r_r;
        // Pin synchronisers
        r_nxt.lclk = {r_r.lclk[1], r_r.lclk[0], gmii_rx_clk};
        r_nxt.g1   = gmii_rx;
        r_nxt.g2   = r_r.g1;
        r_nxt.cl.valid = 1'b0;
        r_nxt.cl.good  = 1'b0;
        r_nxt.cl.bad   = 1'b0;
        r_nxt.svld     = 1'b0;
        r_nxt.sv[ST_BV]   = (r_r.st == S_FRAME) && r_r.g2.dv;
        r_nxt.sv[ST_RSVD] = 1'b0;

        // Bus: write data phase
        if (r_r.wr)
        begin
            if (r_r.adr == OFS_CTRL)
                r_nxt.ctrl = hwdata;
            else if (r_r.adr == OFS_UNI_LO)
                r_nxt.uni_lo = hwdata;
            else if (r_r.adr == OFS_UNI_HI)
                r_nxt.uni_hi = {16'h0000, hwdata[15:0]};
            else if (r_r.adr == OFS_PS_LO)
                r_nxt.ps_lo = hwdata;
            else if (r_r.adr == OFS_PS_HI)
                r_nxt.ps_hi = {16'h0000, hwdata[15:0]};
            for (int i = 0; i < TBL_N; i++)
            begin
                if (TBL_ON && r_r.adr == OFS_TBL + 8'(8 * i))
                    r_nxt.tbl[i][31:0] = hwdata;
                else if (TBL_ON && r_r.adr == OFS_TBL + 8'(8 * i + 4))
                    r_nxt.tbl[i][48:32] = hwdata[16:0];
            end
        end

        // Bus: read data after one wait state
        r_nxt.hrdy = 1'b1;
        r_nxt.rd   = 1'b0;
        if (r_r.rd)
        begin
            r_nxt.hrdata = 32'h0000_0000;
            if (r_r.adr == OFS_CTRL)
                r_nxt.hrdata = r_r.ctrl;
            else if (r_r.adr == OFS_UNI_LO)
                r_nxt.hrdata = r_r.uni_lo;
            else if (r_r.adr == OFS_UNI_HI)
                r_nxt.hrdata = r_r.uni_hi;
            else if (r_r.adr == OFS_PS_LO)
                r_nxt.hrdata = r_r.ps_lo;
            else if (r_r.adr == OFS_PS_HI)
                r_nxt.hrdata = r_r.ps_hi;
            else if (r_r.adr == OFS_STATS)
                r_nxt.hrdata = {4'h0, r_r.sv};
            else if (r_r.adr == OFS_NFRM)
                r_nxt.hrdata = r_r.nfrm;
            for (int i = 0; i < TBL_N; i++)
            begin
                if (TBL_ON && r_r.adr == OFS_TBL + 8'(8 * i))
                    r_nxt.hrdata = r_r.tbl[i][31:0];
                else if (TBL_ON && r_r.adr == OFS_TBL + 8'(8 * i + 4))
                    r_nxt.hrdata = {15'h0000, r_r.tbl[i][48:32]};
            end
        end

        // Bus: address phase
        r_nxt.wr = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            r_nxt.adr  = haddr[7:0];
            r_nxt.wr   = hwrite;
            r_nxt.rd   = !hwrite;
            r_nxt.hrdy = hwrite;
        end

        // Frame engine, one step per line byte
        if (slot)
        begin
            r_nxt.pipe     = {r_r.pipe[PIPE_D-2:0], 9'h000};
            r_nxt.cl.data  = r_r.pipe[PIPE_D-1][7:0];
            r_nxt.cl.valid = r_r.pipe[PIPE_D-1][8] && !rej_now;
            case (r_r.st)
                S_IDLE:
                begin
                    if (r_r.g2.dv && r_r.g2.d == SFD)
                    begin
                        r_nxt.st  = S_FRAME;
                        r_nxt.cnt = 16'h0000;
                        r_nxt.crc = CRC_INIT;
                        r_nxt.er  = 1'b0;
                        r_nxt.rej = 1'b0;
                        r_nxt.lt  = 16'hffff;
                        r_nxt.op  = 16'h0000;
                    end
                end
                S_FRAME:
                begin
                    if (r_r.g2.dv)
                    begin
                        r_nxt.cnt = (r_r.cnt == 16'hffff) ? r_r.cnt : r_r.cnt + 16'h0001;
                        r_nxt.crc = crc_byte(r_r.crc, r_r.g2.d);
                        r_nxt.er  = r_r.er | r_r.g2.er;
                        if (r_r.cnt < 16'h0006)
                            r_nxt.da = {r_r.da[39:0], r_r.g2.d};
                        if (r_r.cnt == 16'h000c || r_r.cnt == 16'h000d)
                            r_nxt.lt = {r_r.lt[7:0], r_r.g2.d};
                        if (r_r.cnt == 16'h000e || r_r.cnt == 16'h000f)
                            r_nxt.op = {r_r.op[7:0], r_r.g2.d};
                        r_nxt.pipe[0] = {!pad_cut, r_r.g2.d};
                        r_nxt.rej = rej_now;
                        if (rej_now)
                            r_nxt.pipe = '0;
                    end
                    else
                    begin
                        // Newest four bytes are the FCS
                        r_nxt.st = S_FLUSH;
                        r_nxt.fl = FLUSH_N;
                        for (int i = 1; i < 5; i++)
                        begin
                            if (!fcs_pass)
                                r_nxt.pipe[i][8] = 1'b0;
                        end
                    end
                end
                S_FLUSH:
                begin
                    r_nxt.fl = r_r.fl - 3'h1;
                    if (r_r.fl == 3'h1)
                    begin
                        // Results and statistics at frame end
                        r_nxt.st       = S_IDLE;
                        r_nxt.cl.good  = !bad && !r_r.rej;
                        r_nxt.cl.bad   = bad && !r_r.rej;
                        r_nxt.svld     = 1'b1;
                        r_nxt.sv[ST_MATCH]  = acc;
                        r_nxt.sv[ST_LENERR] = len_err;
                        r_nxt.sv[ST_BADOP]  = !err0 && is_ctl && (r_r.op != OPC_PAUSE);
                        r_nxt.sv[ST_FCFRM]  = fc_frm;
                        r_nxt.sv[ST_VLAN]   = is_vlan;
                        r_nxt.sv[ST_OOB]    = oob;
                        r_nxt.sv[ST_CTRL]   = is_ctl;
                        r_nxt.sv[ST_LEN_HI:ST_LEN_LO] =
                            (r_r.cnt > LEN_SAT) ? LEN_SAT[13:0] : r_r.cnt[13:0];
                        r_nxt.sv[ST_MCAST]  = r_r.da[40];
                        r_nxt.sv[ST_BCAST]  = (r_r.da == DA_BCAST);
                        r_nxt.sv[ST_FCS]    = fcs_err;
                        r_nxt.sv[ST_BAD]    = bad;
                        r_nxt.sv[ST_GOOD]   = !bad;
                        if (!bad)
                            r_nxt.nfrm = r_r.nfrm + 32'h0000_0001;
                    end
                end
                default:
                    r_nxt.st = S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_r      <= '0;
            r_r.ctrl <= CTRL_RST;
            r_r.hrdy <= 1'b1;
        end
        else
            r_r <= r_nxt;
    end

    // Outputs straight from state, except hresp tied low
    assign hrdata         = r_r.hrdata;
    assign hreadyout      = r_r.hrdy;
    assign hresp          = 1'b0;
    assign rx_client      = r_r.cl;
    assign rx_stats_vec   = r_r.sv;
    assign rx_stats_valid = r_r.svld;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_strobe_single: assert property (rx_stats_valid |=> !rx_stats_valid)
        else $error("stats strobe longer than one cycle");
    a_reject_quiet: assert property (rx_stats_valid && r_r.rej |-> !rx_client.good && !rx_client.bad)
        else $error("rejected frame flagged");
    a_reject_nodata: assert property (r_r.rej && r_r.st != S_IDLE |=> !rx_client.valid)
        else $error("data valid on rejected frame");
    a_flag_stats: assert property (rx_client.good || rx_client.bad |-> rx_stats_valid)
        else $error("flag without statistics strobe");
    a_good_bits: assert property (rx_client.good |-> rx_stats_vec[ST_GOOD] && !rx_stats_vec[ST_BAD])
        else $error("good flag disagrees with vector");
    a_fcs_bad: assert property (rx_stats_valid && rx_stats_vec[ST_FCS] |-> rx_stats_vec[ST_BAD])
        else $error("FCS error not bad");
    a_rsvd_zero: assert property (!rx_stats_vec[ST_RSVD])
        else $error("reserved stats bit set");
    a_match_high: assert property (rx_stats_valid && (!FILT_EN || promisc) |-> rx_stats_vec[ST_MATCH])
        else $error("match low without filtering");
    a_len_bad: assert property (rx_stats_valid && rx_stats_vec[ST_LENERR] |-> rx_stats_vec[ST_BAD])
        else $error("length error not bad");
    a_badop_ctrl: assert property (rx_stats_valid && rx_stats_vec[ST_BADOP]
                                   |-> rx_stats_vec[ST_CTRL] && rx_stats_vec[ST_GOOD])
        else $error("bad opcode bit on non-control frame");
    a_bv_frame: assert property (rx_stats_vec[ST_BV] |-> $past(r_r.st) == S_FRAME)
        else $error("byte valid outside frame");

    c_good: cover property (rx_client.good);
    c_bad: cover property (rx_client.bad);
    c_reject: cover property (rx_stats_valid && r_r.rej);
    c_padcut: cover property (slot && r_r.st == S_FRAME && pad_cut);

endmodule

// file: testbench/rfcs_client_model.sv
// Client model: counts payload bytes, frame flags and statistics strobes.
// Assumes the receive block's client outputs, all on hclk.
`timescale 1ns/1ps

module rfcs_client_model (
    input  wire logic                   hclk,
    input  wire logic                   clr,
    input  wire rfcs_pkg::rfcs_client_t rx_client,
    input  wire logic [27:0]            rx_stats_vec,
    input  wire logic                   rx_stats_valid,
    output logic [31:0]                 n_bytes,
    output logic [31:0]                 n_flags,
    output logic [27:0]                 stats,
    output logic [31:0]                 n_bv,
    output logic [7:0]                  last_b
);
    import rfcs_pkg::*;

    // Take bytes on valid; flags counted as good, bad, strobe nibbles
    always @(posedge hclk)
    begin
        if (clr)
        begin
            n_bytes <= 32'h0;
            n_flags <= 32'h0;
            stats   <= 28'h0;
            n_bv    <= 32'h0;
            last_b  <= 8'h00;
        end
        else
        begin
            n_bytes <= n_bytes + {31'h0, rx_client.valid};
            n_flags <= n_flags + {23'h0, rx_client.good, 3'h0, rx_client.bad, 3'h0, rx_stats_valid};
            if (rx_stats_valid)
                stats <= rx_stats_vec;
            // Byte valid counted per cycle, never used to take data
            n_bv <= n_bv + {31'h0, rx_stats_vec[ST_BV]};
            if (rx_client.valid)
                last_b <= rx_client.data;
        end
    end
endmodule

// file: testbench/testbench.sv
// Testbench: GMII frames in, client bytes, flags and statistics judged.
// Assumes the receive block with default parameters and the client model.
`timescale 1ns/1ps

module testbench;
    import rfcs_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [47:0] UNI = 48'h0211_2233_4455;
    localparam logic [47:0] SA  = 48'h0200_0000_0001;
    localparam logic [47:0] TBA = 48'h0233_4455_6677;
    localparam logic [27:0] MSK = 28'he07_ffe3;
    logic         hclk = 1'b0;
    logic         hresetn = 1'b0;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'b00;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         gclk = 1'b0;
    rfcs_gmii_t   gmii = '0;
    rfcs_client_t client;
    logic [27:0]  sv;
    logic         svalid;
    logic         clr = 1'b0;
    logic [31:0]  n_bytes;
    logic [31:0]  n_flags;
    logic [27:0]  stats;
    logic [31:0]  n_bv;
    logic [7:0]   last_b;
    logic         hresp;
    logic [31:0]  rd;
    int           n_mismatch = 0;
    int           samples_checked = 0;

    always #2 hclk = ~hclk;

    rfcs_rx_filter i_rfcs_rx_filter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gmii_rx_clk(gclk), .gmii_rx(gmii),
        .uni_addr_in(48'h0), .rx_client(client), .rx_stats_vec(sv), .rx_stats_valid(svalid));

    rfcs_client_model i_rfcs_client_model (.hclk(hclk), .clr(clr), .rx_client(client),
        .rx_stats_vec(sv), .rx_stats_valid(svalid), .n_bytes(n_bytes), .n_flags(n_flags), .stats(stats),
        .n_bv(n_bv), .last_b(last_b));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // One single AHB-Lite word transfer, address then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rdat = hrdata;
    endtask

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] x;
        x = c ^ {24'h0, b};
        for (int k = 0; k < 8; k++)
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        return x;
    endfunction

    // Preamble, frame with FCS, then idle slots; line clock 160 ns
    task automatic send(input logic [47:0] da, input logic [15:0] lt, input int nd);
        logic [7:0]  q[$];
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 6; i++) q.push_back(da[47-8*i -: 8]);
        for (int i = 0; i < 6; i++) q.push_back(SA[47-8*i -: 8]);
        q.push_back(lt[15:8]);
        q.push_back(lt[7:0]);
        for (int i = 0; i < nd; i++) q.push_back(8'(i));
        foreach (q[i]) c = crc_step(c, q[i]);
        c = ~c;
        for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
        for (int i = 0; i < 8; i++) q.push_front(i == 0 ? SFD : 8'h55);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        for (int i = 0; i < q.size() + 12; i++)
        begin
            gclk <= 1'b1;
            gmii <= (i < q.size()) ? {1'b1, 1'b0, q[i]} : {1'b0, 1'b0, ~gmii.d};
            repeat (20) @(posedge hclk);
            gclk <= 1'b0;
            repeat (20) @(posedge hclk);
        end
    endtask

    function automatic logic [27:0] stv(input logic g, b, l, m, input int len);
        return {m, 1'b0, l, 6'h0, 14'(len), 3'h0, b, g};
    endfunction

    task automatic expect_frame(input int nb, input logic [11:0] fl, input logic [27:0] st);
        chk(n_bytes, 32'(nb), "payload bytes");
        chk(n_flags, {20'h0, fl}, "good bad strobe counts");
        chk({4'h0, stats & MSK}, {4'h0, st}, "statistics fields");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_regs;
        ahb(1'b0, OFS_CTRL, 32'h0, rd);
        chk(rd, CTRL_RST, "control reset value");
        chk({31'h0, hresp}, 32'h0, "response okay");
        ahb(1'b0, 8'h30, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        ahb(1'b1, OFS_UNI_LO, UNI[31:0], rd);
        ahb(1'b1, OFS_UNI_HI, {16'h0, UNI[47:32]}, rd);
        ahb(1'b0, OFS_UNI_LO, 32'h0, rd);
        chk(rd, UNI[31:0], "unicast readback");
    endtask

    task automatic sc_check_on;
        send(UNI, 16'd10, 46);
        expect_frame(24, 12'h101, stv(1, 0, 0, 1, 64));
        chk({24'h0, last_b}, 32'h09, "last byte before pad");
        chk({31'h0, (n_bv > 32'd2520) && (n_bv < 32'd2600)}, 32'h1, "byte valid cycles");
        send(UNI, 16'd100, 46);
        expect_frame(60, 12'h011, stv(0, 1, 1, 1, 64));
    endtask

    task automatic sc_check_off;
        ahb(1'b1, OFS_CTRL, 32'h0, rd);
        send(UNI, 16'd100, 46);
        expect_frame(60, 12'h101, stv(1, 0, 0, 1, 64));
        send(UNI, 16'd10, 46);
        expect_frame(60, 12'h101, stv(1, 0, 0, 1, 64));
        chk({24'h0, last_b}, 32'h2d, "last byte before FCS");
        send(UNI, 16'd10, 50);
        expect_frame(64, 12'h011, stv(0, 1, 1, 1, 68));
    endtask

    task automatic sc_filter;
        send(48'h0299_0000_0001, 16'd10, 46);
        expect_frame(0, 12'h001, stv(1, 0, 0, 0, 64));
        send(DA_BCAST, 16'd10, 46);
        expect_frame(60, 12'h101, stv(1, 0, 0, 1, 64));
    endtask

    task automatic sc_table;
        send(TBA, 16'd10, 46);
        expect_frame(0, 12'h001, stv(1, 0, 0, 0, 64));
        ahb(1'b1, OFS_TBL, TBA[31:0], rd);
        ahb(1'b1, OFS_TBL + 8'h04, {15'h0, 1'b1, TBA[47:32]}, rd);
        send(TBA, 16'd10, 46);
        expect_frame(60, 12'h101, stv(1, 0, 0, 1, 64));
    endtask

    // VLAN reception and flow control on, length checks off
    task automatic sc_ctrl_vlan;
        ahb(1'b1, OFS_CTRL, 32'h0000_0028, rd);
        send(UNI, TYPE_VLAN, 46);
        expect_frame(60, 12'h101, stv(1, 0, 0, 1, 64));
        chk({31'h0, stats[ST_VLAN]}, 32'h1, "vlan bit");
        send(DA_PAUSE, TYPE_CTRL, 46);
        expect_frame(60, 12'h011, stv(0, 1, 0, 1, 64));
        chk({31'h0, stats[ST_FCFRM]}, 32'h1, "pause acted on");
    endtask

    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        sc_regs();
        sc_check_on();
        sc_check_off();
        sc_filter();
        sc_table();
        sc_ctrl_vlan();
        end_sim();
    end
endmodule
